// ### core/freq_current_detect_flags.sv
`timescale 1ns/100ps
`default_nettype none
`include "flag_detect_defines.svh"

module freq_current_detect_flags
  import flag_detect_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] set_freq,
  input wire logic rev_dir,
  input wire logic dc_brake_active,
  input wire logic drive_running,
  input wire logic autotune_active,
  input wire logic [15:0] out_current,
  input wire logic ground_fault_trip,
  output logic up_to_freq_flag,
  output logic freq_detect_flag,
  output logic overcurrent_detect_flag,
  output logic zero_current_flag,
  output logic hardware_fault_flag,
  output logic [2:0] terminal_out,
  output logic irq
);

  // ----------------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------------
  localparam logic [6:0] HOLD_TICKS = 7'(`HOLD_TIME_MS);
  localparam logic [17:0] TICK_LAST = 18'(MS_CYCLES - 1);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // one qualified detector step, evaluated on each ms tick
  function automatic detect_s qualify(input logic cond, input detect_s cur,
                                      input logic [13:0] limit);
    detect_s nxt;
    logic hit;
    nxt = cur;
    hit = 1'b0;
    if (cond) begin
      if (cur.timer >= limit) begin
        hit = 1'b1;
      end else begin
        nxt.timer = cur.timer + 14'h0001;
      end
    end else begin
      nxt.timer = 14'h0000;
    end
    if (hit) begin
      nxt.flag = 1'b1;
      nxt.hold = HOLD_TICKS;
    end else if (cur.hold != 7'h00) begin
      nxt.hold = cur.hold - 7'h01;
    end else begin
      nxt.flag = 1'b0;
    end
    return nxt;
  endfunction

  // terminal level for one function code; unknown codes stay off
  function automatic logic term_drive(input logic [7:0] code, input logic [4:0] fl);
    logic lvl;
    lvl = 1'b0;
    unique case (code)
      `CODE_UPTO: lvl = fl[`BIT_UPTO];
      `CODE_UPTO_N: lvl = ~fl[`BIT_UPTO];
      `CODE_FDET: lvl = fl[`BIT_FDET];
      `CODE_FDET_N: lvl = ~fl[`BIT_FDET];
      `CODE_OC: lvl = fl[`BIT_OC];
      `CODE_OC_N: lvl = ~fl[`BIT_OC];
      `CODE_ZC: lvl = fl[`BIT_ZC];
      `CODE_ZC_N: lvl = ~fl[`BIT_ZC];
      `CODE_HW: lvl = fl[`BIT_HW];
      `CODE_HW_N: lvl = ~fl[`BIT_HW];
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // byte-lane merge for a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  state_s s;
  state_s next_s;

  // comparison helpers
  logic ms_tick;
  logic [15:0] fdiff;
  logic [22:0] diff_scaled;
  logic [22:0] band_scaled;
  logic [15:0] level_sel;
  logic current_active;
  logic oc_cond;
  logic zc_cond;
  logic [4:0] flags_now;
  logic [4:0] flags_next;
  logic [31:0] wr_word;
  logic wr_en;
  logic rd_setup;
  detect_s oc_step;
  detect_s zc_step;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    ms_tick = (s.prescale == TICK_LAST);
    next_s.prescale = ms_tick ? 18'h00000 : s.prescale + 18'h00001;

    // out_freq is the pre slip compensation value from the speed loop
    fdiff = (out_freq >= set_freq) ? out_freq - set_freq : set_freq - out_freq;
    diff_scaled = 23'(fdiff) * 23'h000064;
    band_scaled = 23'(set_freq) * 23'(s.band);
    // reverse level of 9999 falls back to the forward level
    level_sel = (rev_dir && s.rev_level != `REV_SAME_AS_FWD) ? s.rev_level
                                                             : s.fwd_level;
    next_s.upto = !dc_brake_active && (diff_scaled <= band_scaled);
    next_s.fdet = !dc_brake_active && (out_freq >= level_sel);

    // auto tuning counts as operation for current detection
    current_active = drive_running || autotune_active;
    oc_cond = current_active && (out_current > 16'(s.cur_level));
    zc_cond = current_active && (s.zero_level != 12'h000) &&
              (out_current < 16'(s.zero_level));

    // sampled once per ms: well inside the 0.1 s response, immune to pwm ripple
    oc_step = qualify(oc_cond, '{flag: s.oc, hold: s.oc_hold, timer: s.oc_timer},
                      s.cur_delay);
    zc_step = qualify(zc_cond, '{flag: s.zc, hold: s.zc_hold, timer: s.zc_timer},
                      {4'h0, s.zero_time});
    if (ms_tick) begin
      next_s.oc = oc_step.flag;
      next_s.oc_hold = oc_step.hold;
      next_s.oc_timer = oc_step.timer;
      next_s.zc = zc_step.flag;
      next_s.zc_hold = zc_step.hold;
      next_s.zc_timer = zc_step.timer;
    end
    // a zero level switches the detector off at once, hold included
    if (s.zero_level == 12'h000) begin
      next_s.zc = 1'b0;
      next_s.zc_hold = 7'h00;
      next_s.zc_timer = 14'h0000;
    end

    // ground fault latches until drive reset, whatever trip code is shown
    next_s.hw_fault = s.hw_fault || ground_fault_trip;

    flags_now = {s.hw_fault, s.zc, s.oc, s.fdet, s.upto};
    flags_next = {next_s.hw_fault, next_s.zc, next_s.oc, next_s.fdet, next_s.upto};
    for (int t = 0; t < 3; t++) begin
      next_s.term[t] = term_drive(s.assign_codes[t*8 +: 8], flags_now);
    end

    // apb: read data captured in setup so the access phase needs no wait
    rd_setup = psel && !penable;
    wr_en = psel && penable && pwrite;
    if (rd_setup) begin
      next_s.rdata = 32'h00000000;
      next_s.slverr = 1'b0;
      unique case (paddr)
        `OFF_FREQ_BAND: next_s.rdata = {25'h0000000, s.band};
        `OFF_FWD_LEVEL: next_s.rdata = {16'h0000, s.fwd_level};
        `OFF_REV_LEVEL: next_s.rdata = {16'h0000, s.rev_level};
        `OFF_CUR_LEVEL: next_s.rdata = {20'h00000, s.cur_level};
        `OFF_CUR_DELAY: next_s.rdata = {18'h00000, s.cur_delay};
        `OFF_ZERO_LEVEL: next_s.rdata = {20'h00000, s.zero_level};
        `OFF_ZERO_TIME: next_s.rdata = {22'h000000, s.zero_time};
        `OFF_TERM_ASSIGN: next_s.rdata = {8'h00, s.assign_codes};
        `OFF_FLAGS: next_s.rdata = {27'h0000000, flags_now};
        `OFF_IRQ_STATUS: next_s.rdata = {27'h0000000, s.irq_status};
        `OFF_IRQ_MASK: next_s.rdata = {27'h0000000, s.irq_mask};
        default: next_s.slverr = 1'b1;
      endcase
    end

    // register writes take effect at the access edge
    wr_word = 32'h00000000;
    if (wr_en) begin
      unique case (paddr)
        `OFF_FREQ_BAND: begin
          wr_word = merge({25'h0000000, s.band}, pwdata, pstrb);
          next_s.band = wr_word[6:0];
        end
        `OFF_FWD_LEVEL: begin
          wr_word = merge({16'h0000, s.fwd_level}, pwdata, pstrb);
          next_s.fwd_level = wr_word[15:0];
        end
        `OFF_REV_LEVEL: begin
          wr_word = merge({16'h0000, s.rev_level}, pwdata, pstrb);
          next_s.rev_level = wr_word[15:0];
        end
        `OFF_CUR_LEVEL: begin
          wr_word = merge({20'h00000, s.cur_level}, pwdata, pstrb);
          next_s.cur_level = wr_word[11:0];
        end
        `OFF_CUR_DELAY: begin
          wr_word = merge({18'h00000, s.cur_delay}, pwdata, pstrb);
          next_s.cur_delay = wr_word[13:0];
        end
        `OFF_ZERO_LEVEL: begin
          wr_word = merge({20'h00000, s.zero_level}, pwdata, pstrb);
          next_s.zero_level = wr_word[11:0];
        end
        `OFF_ZERO_TIME: begin
          wr_word = merge({22'h000000, s.zero_time}, pwdata, pstrb);
          next_s.zero_time = wr_word[9:0];
        end
        `OFF_TERM_ASSIGN: begin
          wr_word = merge({8'h00, s.assign_codes}, pwdata, pstrb);
          next_s.assign_codes = wr_word[23:0];
        end
        `OFF_IRQ_STATUS: begin
          wr_word = merge(32'h00000000, pwdata, pstrb);
          next_s.irq_status = s.irq_status & ~wr_word[4:0];
        end
        `OFF_IRQ_MASK: begin
          wr_word = merge({27'h0000000, s.irq_mask}, pwdata, pstrb);
          next_s.irq_mask = wr_word[4:0];
        end
        default: wr_word = 32'h00000000;
      endcase
    end
    // rising flags set sticky bits; applied after the clear so set wins
    next_s.irq_status = next_s.irq_status | (flags_next & ~flags_now);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.band <= `RST_FREQ_BAND;
      s.fwd_level <= `RST_FWD_LEVEL;
      s.rev_level <= `RST_REV_LEVEL;
      s.cur_level <= `RST_CUR_LEVEL;
      s.cur_delay <= `RST_CUR_DELAY;
      s.zero_level <= `RST_ZERO_LEVEL;
      s.zero_time <= `RST_ZERO_TIME;
      s.assign_codes <= `RST_TERM_ASSIGN;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign prdata = s.rdata;
  assign pslverr = s.slverr && psel && penable;
  assign pready = 1'b1; // zero wait states
  assign up_to_freq_flag = s.upto;
  assign freq_detect_flag = s.fdet;
  assign overcurrent_detect_flag = s.oc;
  assign zero_current_flag = s.zc;
  assign hardware_fault_flag = s.hw_fault;
  assign terminal_out = s.term;
  assign irq = |(s.irq_status & s.irq_mask);

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence oc_rise_s;
    $rose(s.oc);
  endsequence

  sequence oc_low_s;
    !s.oc;
  endsequence

  dc_brake_off_a: assert property (dc_brake_active |=> !s.upto && !s.fdet)
    else $error("frequency flag set during dc braking");

  fdet_level_a: assert property (!dc_brake_active && !rev_dir && out_freq >= s.fwd_level
                                 |=> s.fdet)
    else $error("freq flag missing above forward level");

  rev_level_a: assert property (!dc_brake_active && rev_dir &&
                                s.rev_level != `REV_SAME_AS_FWD &&
                                out_freq < s.rev_level |=> !s.fdet)
    else $error("reverse rotation ignored reverse level");

  upto_band_a: assert property (!dc_brake_active && out_freq == set_freq |=> s.upto)
    else $error("up to frequency missing at exact match");

  oc_hold_a: assert property (s.oc_hold != 7'h00 |-> s.oc)
    else $error("overcurrent flag dropped during hold");

  oc_cause_a: assert property (oc_rise_s |-> $past(ms_tick) && $past(oc_cond))
    else $error("overcurrent flag rose without cause");

  oc_hold_load_a: assert property (oc_rise_s |-> s.oc_hold == HOLD_TICKS)
    else $error("hold not loaded on overcurrent");

  zc_hold_a: assert property (s.zc_hold != 7'h00 |-> s.zc)
    else $error("zero current flag dropped during hold");

  zc_off_a: assert property (s.zero_level == 12'h000 |=> !s.zc)
    else $error("zero current flag set while disabled");

  timer_restart_a: assert property (ms_tick && !oc_cond ##1 oc_low_s
                                    |-> s.oc_timer == 14'h0000)
    else $error("overcurrent timer not restarted");

  hw_fault_a: assert property (ground_fault_trip |=> hardware_fault_flag [*2])
    else $error("ground fault did not raise hardware fault flag");

  term_map_a: assert property (s.assign_codes[15:8] == `CODE_FDET_N
                               |=> terminal_out[1] == !$past(s.fdet))
    else $error("inverted freq flag not on terminal");

  term_oc_a: assert property (s.assign_codes[7:0] == `CODE_OC
                              |=> terminal_out[0] == $past(s.oc))
    else $error("overcurrent flag not on terminal");

  irq_set_a: assert property (oc_rise_s |-> s.irq_status[`BIT_OC])
    else $error("overcurrent event did not set status");

endmodule // freq_current_detect_flags

`default_nettype wire

// ### inc/flag_detect_defines.svh
`ifndef FLAG_DETECT_DEFINES_SVH
`define FLAG_DETECT_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFF_FREQ_BAND   12'h000
`define OFF_FWD_LEVEL   12'h004
`define OFF_REV_LEVEL   12'h008
`define OFF_CUR_LEVEL   12'h00c
`define OFF_CUR_DELAY   12'h010
`define OFF_ZERO_LEVEL  12'h014
`define OFF_ZERO_TIME   12'h018
`define OFF_TERM_ASSIGN 12'h01c
`define OFF_FLAGS       12'h020
`define OFF_IRQ_STATUS  12'h024
`define OFF_IRQ_MASK    12'h028

// ----------------------------------------------------------------------
// reset values (frequency in 0.1 Hz, current in 0.1 %, times in ms)
// ----------------------------------------------------------------------
`define RST_FREQ_BAND   7'h0a
`define RST_FWD_LEVEL   16'h003c
`define RST_REV_LEVEL   16'h270f
`define RST_CUR_LEVEL   12'h5dc
`define RST_CUR_DELAY   14'h0000
`define RST_ZERO_LEVEL  12'h032
`define RST_ZERO_TIME   10'h1f4
`define RST_TERM_ASSIGN 24'h000400
`define REV_SAME_AS_FWD 16'h270f

// ----------------------------------------------------------------------
// flag bit positions in flags, irq status and irq mask
// ----------------------------------------------------------------------
`define BIT_UPTO 0
`define BIT_FDET 1
`define BIT_OC 2
`define BIT_ZC 3
`define BIT_HW 4

// ----------------------------------------------------------------------
// terminal function codes
// ----------------------------------------------------------------------
`define CODE_UPTO   8'h01
`define CODE_UPTO_N 8'h65
`define CODE_FDET   8'h04
`define CODE_FDET_N 8'h68
`define CODE_OC   8'h0c
`define CODE_OC_N 8'h70
`define CODE_ZC   8'h0d
`define CODE_ZC_N 8'h71
`define CODE_HW   8'h5b
`define CODE_HW_N 8'hbf

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS  4
`define TICK_PERIOD_NS 1000000
`define HOLD_TIME_MS   100

`endif

// ### inc/flag_detect_pkg.sv
`default_nettype none

package flag_detect_pkg;

  // whole block state, registered as one word
  typedef struct packed {
    logic [6:0] band;
    logic [15:0] fwd_level;
    logic [15:0] rev_level;
    logic [11:0] cur_level;
    logic [13:0] cur_delay;
    logic [11:0] zero_level;
    logic [9:0] zero_time;
    logic [23:0] assign_codes;
    logic [4:0] irq_status;
    logic [4:0] irq_mask;
    logic [31:0] rdata;
    logic slverr;
    logic [17:0] prescale;
    logic [13:0] oc_timer;
    logic [6:0] oc_hold;
    logic [13:0] zc_timer;
    logic [6:0] zc_hold;
    logic upto;
    logic fdet;
    logic oc;
    logic zc;
    logic hw_fault;
    logic [2:0] term;
  } state_s;

  // timer, hold count and flag of one qualified current detector
  typedef struct packed {
    logic flag;
    logic [6:0] hold;
    logic [13:0] timer;
  } detect_s;

endpackage

`default_nettype wire

// ### sim/terminal_reader.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// far side: controller latching terminals
// ----------------------------------------
module terminal_reader (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] terminal_out,
  output logic [2:0] seen
);
  // one input stage, as a real controller would sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= 3'h0;
    end else begin
      seen <= terminal_out;
    end
  end
endmodule // terminal_reader

`default_nettype wire

// ### sim/freq_current_detect_flags_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "flag_detect_defines.svh"

module freq_current_detect_flags_tb
  import flag_detect_pkg::*;
  ;
  // short ms tick keeps the 100 ms holds cheap
  localparam int MS = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic rev_dir, dc_brake_active, drive_running, autotune_active, ground_fault_trip;
  logic upto, fdet, oc, zc, hw;
  logic [11:0] paddr;
  logic [3:0] pstrb, strobe;
  logic [31:0] pwdata, prdata;
  logic [15:0] out_freq, set_freq, out_current;
  logic [2:0] terminal_out, seen;
  int n_fail, checks;

  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  freq_current_detect_flags #(.MS_CYCLES(MS)) freq_current_detect_flags_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .out_freq(out_freq),
    .set_freq(set_freq),
    .rev_dir(rev_dir),
    .dc_brake_active(dc_brake_active),
    .drive_running(drive_running),
    .autotune_active(autotune_active),
    .out_current(out_current),
    .ground_fault_trip(ground_fault_trip),
    .up_to_freq_flag(upto),
    .freq_detect_flag(fdet),
    .overcurrent_detect_flag(oc),
    .zero_current_flag(zc),
    .hardware_fault_flag(hw),
    .terminal_out(terminal_out),
    .irq(irq)
  );
  terminal_reader terminal_reader_inst (
    .pclk(pclk),
    .presetn(presetn),
    .terminal_out(terminal_out),
    .seen(seen)
  );

  // free-running 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic complete_run;
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
    checks++;
    if (s !== x) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, s, x);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // request held until pready is seen; a bounded wait guards a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strobe;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) n_fail++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, "rdata");
    chk(32'(e), 32'(xe), "pslverr");
  endtask

  task automatic fq(input logic [15:0] o, s, input logic r, b);
    @(posedge pclk);
    out_freq <= o;
    set_freq <= s;
    rev_dir <= r;
    dc_brake_active <= b;
    cyc(3);
  endtask

  task automatic cu(input logic [15:0] c);
    @(posedge pclk);
    out_current <= c;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(`OFF_FREQ_BAND, 32'ha, 1'b0);
    rd(`OFF_FWD_LEVEL, 32'h3c, 1'b0);
    rd(`OFF_REV_LEVEL, 32'h270f, 1'b0);
    rd(`OFF_CUR_LEVEL, 32'h5dc, 1'b0);
    rd(`OFF_CUR_DELAY, 32'h0, 1'b0);
    rd(`OFF_ZERO_LEVEL, 32'h32, 1'b0);
    rd(`OFF_ZERO_TIME, 32'h1f4, 1'b0);
    rd(`OFF_TERM_ASSIGN, 32'h400, 1'b0);
    rd(`OFF_IRQ_MASK, 32'h0, 1'b0);
    rd(12'h040, 32'h0, 1'b1);
    // lane 0 only: upper byte of the level keeps its old zero
    strobe = 4'h1;
    wr(`OFF_FWD_LEVEL, 32'h0000aa11);
    strobe = 4'hf;
    rd(`OFF_FWD_LEVEL, 32'h11, 1'b0);
    wr(`OFF_FWD_LEVEL, 32'h3c);
  endtask

  task automatic t_freq;
    fq(16'd60, 16'd500, 1'b0, 1'b0);
    chk(32'(fdet), 32'h1, "fdet at level");
    chk(32'(terminal_out), 32'h2, "fdet default term");
    fq(16'd59, 16'd500, 1'b0, 1'b0);
    chk(32'(fdet), 32'h0, "fdet below");
    fq(16'd450, 16'd500, 1'b0, 1'b0);
    chk(32'(upto), 32'h1, "upto low edge");
    fq(16'd449, 16'd500, 1'b0, 1'b0);
    chk(32'(upto), 32'h0, "upto outside");
    fq(16'd551, 16'd500, 1'b0, 1'b0);
    chk(32'(upto), 32'h0, "upto above");
    wr(`OFF_REV_LEVEL, 32'd100);
    fq(16'd60, 16'd500, 1'b0, 1'b0);
    chk(32'(fdet), 32'h1, "fdet fwd keeps level");
    fq(16'd99, 16'd500, 1'b1, 1'b0);
    chk(32'(fdet), 32'h0, "fdet rev below");
    fq(16'd100, 16'd500, 1'b1, 1'b0);
    chk(32'(fdet), 32'h1, "fdet rev level");
    wr(`OFF_REV_LEVEL, 32'(`REV_SAME_AS_FWD));
    fq(16'd60, 16'd500, 1'b1, 1'b0);
    chk(32'(fdet), 32'h1, "fdet rev shared");
    fq(16'd500, 16'd500, 1'b0, 1'b1);
    chk(32'({upto, fdet}), 32'h0, "dc brake");
    fq(16'd500, 16'd500, 1'b0, 1'b0);
    rd(`OFF_FLAGS, 32'h3, 1'b0);
    // terminal codes with both frequency flags high, current flags low
    wr(`OFF_TERM_ASSIGN, 32'h00046501);
    cyc(3);
    chk(32'(terminal_out), 32'h5, "codes upto fdet");
    chk(32'(seen), 32'h5, "far side");
    wr(`OFF_TERM_ASSIGN, 32'h00700c68);
    cyc(3);
    chk(32'(terminal_out), 32'h4, "codes fdet oc");
    wr(`OFF_TERM_ASSIGN, 32'h0071bf0d);
    cyc(3);
    chk(32'(terminal_out), 32'h6, "codes zc hw");
    fq(16'd0, 16'd500, 1'b0, 1'b0);
  endtask

  task automatic t_oc;
    int n;
    wr(`OFF_CUR_DELAY, 32'h2);
    wr(`OFF_TERM_ASSIGN, 32'h0071700c);
    wr(`OFF_IRQ_MASK, 32'h4);
    wr(`OFF_IRQ_STATUS, 32'h1f);
    @(posedge pclk);
    drive_running <= 1'b1;
    // short burst, a low tick, then a new qualification window
    cu(16'd1501);
    cyc(MS + MS / 2);
    cu(16'd800);
    cyc(MS + 1);
    cu(16'd1501);
    cyc(2 * MS - 1);
    chk(32'(oc), 32'h0, "oc early");
    n = 0;
    while (oc !== 1'b1 && n < 3 * MS) begin
      cyc(1);
      n++;
    end
    chk(32'(oc), 32'h1, "oc set");
    cyc(2);
    chk(32'(terminal_out), 32'h5, "oc term");
    chk(32'(irq), 32'h1, "irq on");
    cu(16'd800);
    cyc(90 * MS);
    chk(32'(oc), 32'h1, "oc hold");
    cyc(20 * MS);
    chk(32'(oc), 32'h0, "oc clear");
    rd(`OFF_IRQ_STATUS, 32'h4, 1'b0);
    wr(`OFF_IRQ_STATUS, 32'h4);
    cyc(2);
    chk(32'(irq), 32'h0, "irq clear");
  endtask

  task automatic t_zc;
    int n;
    wr(`OFF_ZERO_TIME, 32'h3);
    @(posedge pclk);
    drive_running <= 1'b0;
    autotune_active <= 1'b1;
    cu(16'd40);
    cyc(3 * MS - 1);
    chk(32'(zc), 32'h0, "zc early");
    n = 0;
    while (zc !== 1'b1 && n < 3 * MS) begin
      cyc(1);
      n++;
    end
    chk(32'(zc), 32'h1, "zc set");
    cu(16'd800);
    cyc(90 * MS);
    chk(32'(zc), 32'h1, "zc hold");
    cu(16'd40);
    wr(`OFF_ZERO_LEVEL, 32'h0);
    cyc(3);
    chk(32'(zc), 32'h0, "zc off");
  endtask

  task automatic t_hw;
    @(posedge pclk);
    autotune_active <= 1'b0;
    wr(`OFF_IRQ_STATUS, 32'h1f);
    @(posedge pclk);
    ground_fault_trip <= 1'b1;
    @(posedge pclk);
    ground_fault_trip <= 1'b0;
    cyc(3);
    chk(32'(hw), 32'h1, "hw set");
    chk(32'(irq), 32'h0, "irq masked");
    rd(`OFF_IRQ_STATUS, 32'h10, 1'b0);
    rd(`OFF_FLAGS, 32'h10, 1'b0);
    wr(`OFF_IRQ_MASK, 32'h10);
    cyc(2);
    chk(32'(irq), 32'h1, "irq unmasked");
    wr(`OFF_IRQ_STATUS, 32'h10);
    cyc(2);
    chk(32'(irq), 32'h0, "irq w1c");
    chk(32'(hw), 32'h1, "hw latched");
    // positive code for the fault flag, other terminals unassigned
    wr(`OFF_TERM_ASSIGN, 32'h0000005b);
    cyc(3);
    chk(32'(terminal_out), 32'h1, "hw code");
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    n_fail = 0;
    checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    strobe = 4'hf;
    out_freq = 16'h0;
    set_freq = 16'h0;
    out_current = 16'h0;
    rev_dir = 1'b0;
    dc_brake_active = 1'b0;
    drive_running = 1'b0;
    autotune_active = 1'b0;
    ground_fault_trip = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_freq;
    t_oc;
    t_zc;
    t_hw;
    complete_run;
  end

  // roughly eight times the expected run
  initial begin
    #60000;
    n_fail++;
    complete_run;
  end
endmodule // freq_current_detect_flags_tb

`default_nettype wire
